// ### hw/psdc_pkg.sv
package psdc_pkg;
  localparam int unsigned NUM_PD    = 6;
  localparam int unsigned NUM_MOD   = 12;
  localparam int unsigned NUM_CORE  = 3;
  localparam logic [11:0] ADDR_GO       = 12'h000;
  localparam logic [11:0] ADDR_PEND     = 12'h004;
  localparam logic [11:0] ADDR_PD_NEXT  = 12'h008;
  localparam logic [11:0] ADDR_PD_STAT  = 12'h00C;
  localparam logic [11:0] ADDR_MOD_NEXT = 12'h010;
  localparam logic [11:0] ADDR_MOD_STAT = 12'h014;
  localparam logic [11:0] ADDR_CORE_RST = 12'h018;
  localparam logic [11:0] ADDR_EMU      = 12'h01C;
  localparam logic [5:0]  PD_SWITCHABLE  = 6'h36;
  localparam logic [5:0]  PD_RESET       = 6'h01;
  localparam logic [11:0] MOD_SWITCHABLE = 12'h6C0;
  localparam logic [11:0] MOD_ALWAYS_ON  = 12'h838;
  localparam logic [11:0] MOD_DEDICATED  = 12'h0C0;
  localparam logic [2:0]  CORE_RST_INIT  = 3'h7;
  localparam int unsigned CORE_MOD_BASE  = 3;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
  localparam int unsigned STEP_WAIT      = 2;

  typedef enum logic [2:0] {
    PSDC_IDLE,
    PSDC_WAKE_MEM,
    PSDC_START_CLK,
    PSDC_WAIT_ACK,
    PSDC_RELEASE
  } psdc_state_e;

  typedef struct packed {
    logic [NUM_MOD-1:0] clk_stop_req;
    logic [NUM_MOD-1:0] clk_gate_en;
    logic [NUM_MOD-1:0] mod_rst_n;
    logic [NUM_CORE-1:0] core_local_reset_n;
  } psdc_out_s;

  typedef struct packed {
    logic       hold;
    logic       force_on;
  } psdc_emu_s;
endpackage

// ### hw/psdc_apb_slave.sv
`timescale 1ns/1ps
module psdc_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] rdata_in,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_stb,
  output logic             rd_stb
);
  // Zero wait states: every access completes in its first access cycle
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    wr_stb  = psel & penable & pwrite;
    rd_stb  = psel & ~penable & ~pwrite;
  end
endmodule

// ### hw/psdc_top.sv
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [RL1] Software requests memory wake, module clock and core reset via registers.
// [RL2] Global unit wakes memories of each switchable power domain independently.
// [RL3] Dedicated-clock modules request source clock start from clock generator.
// [RL4] Shared-clock modules are gated locally by this block.
// [RL5] Power domain 0 permanently on with clocks running.
// [RL6] Domains 1,2,4,5 software controlled; domain 3 reserved.
// [RL7] Modules 3,4,5,11 always on; 6,7,9,10 software; 0,1,2,8 reserved.
// [RL8] Each domain and module keeps its own independent state.
// [RL9] Emulation control can hold or force module state.
// [RL10] Domains ON or OFF; switchable domains start OFF.
// [RL11] Module is enabled or held in reset with clock stopped.
// [RL12] Pending flag clears only once the new state is reached.
// [RL13] Combined trigger: wake memory, start clock, then release reset.
// [RL14] Reserved indices ignored; their status reads fixed.
// [RL15] Reset returns all states to power-on values.
module psdc_top #(
  parameter int unsigned NUM_PD  = psdc_pkg::NUM_PD,
  parameter int unsigned NUM_MOD = psdc_pkg::NUM_MOD
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NUM_MOD-1:0]    clk_src_ack,
  input  wire logic                  emu_hold,
  input  wire logic                  emu_force_on,
  output logic [NUM_PD-1:0]          mem_sleep,
  output psdc_pkg::psdc_out_s        mod_out,
  output logic                       transition_pending
);
  logic                      wr_stb;
  logic                      rd_stb;
  logic [NUM_PD-1:0]         pd_on_q,      pd_on_d;
  logic [NUM_PD-1:0]         pd_next_q,    pd_next_d;
  logic [NUM_MOD-1:0]        mod_en_q,     mod_en_d;
  logic [NUM_MOD-1:0]        mod_next_q,   mod_next_d;
  logic [NUM_MOD-1:0]        clk_on_q,     clk_on_d;
  logic [2:0]                core_rst_q,   core_rst_d;
  logic [NUM_PD-1:0]         go_pend_q,    go_pend_d;
  logic [1:0]                emu_ctl_q,    emu_ctl_d;
  logic [31:0]               prdata_q,     prdata_d;
  logic [1:0]                wait_q,       wait_d;
  psdc_pkg::psdc_state_e     state_q,      state_d;
  psdc_pkg::psdc_emu_s       emu;
  logic                      emu_hold_all;
  logic [NUM_MOD-1:0]        mod_target;
  logic [NUM_MOD-1:0]        ack_need;

  psdc_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .rdata_in (prdata_q),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb)
  );

  // Emulation inputs OR with software emulation bits
  always_comb begin
    emu.hold     = emu_hold | emu_ctl_q[0];
    emu.force_on = emu_force_on | emu_ctl_q[1];
    emu_hold_all = emu.hold;
  end

  // Requested module set, reserved and always-on bits masked off
  always_comb begin
    mod_target = (mod_next_q | {NUM_MOD{emu.force_on}}) & psdc_pkg::MOD_SWITCHABLE; // [RL14]
    ack_need   = mod_target & ~mod_en_q & psdc_pkg::MOD_DEDICATED;
  end

  // Register writes and read mux
  always_comb begin
    pd_next_d  = pd_next_q;
    mod_next_d = mod_next_q;
    core_rst_d = core_rst_q;
    emu_ctl_d  = emu_ctl_q;
    prdata_d   = prdata_q;
    if (wr_stb) begin
      if (paddr == psdc_pkg::ADDR_PD_NEXT) begin
        pd_next_d = pwdata[NUM_PD-1:0] & psdc_pkg::PD_SWITCHABLE; // [RL6] [RL14]
      end else if (paddr == psdc_pkg::ADDR_MOD_NEXT) begin
        mod_next_d = pwdata[NUM_MOD-1:0] & psdc_pkg::MOD_SWITCHABLE; // [RL7] [RL14]
      end else if (paddr == psdc_pkg::ADDR_CORE_RST) begin
        core_rst_d = pwdata[2:0]; // [RL1]
      end else if (paddr == psdc_pkg::ADDR_EMU) begin
        emu_ctl_d = pwdata[1:0]; // [RL9]
      end
    end
    if (rd_stb) begin
      if (paddr == psdc_pkg::ADDR_PEND) begin
        prdata_d = {26'h0, go_pend_q};
      end else if (paddr == psdc_pkg::ADDR_PD_NEXT) begin
        prdata_d = {26'h0, pd_next_q};
      end else if (paddr == psdc_pkg::ADDR_PD_STAT) begin
        prdata_d = {26'h0, pd_on_q};
      end else if (paddr == psdc_pkg::ADDR_MOD_NEXT) begin
        prdata_d = {20'h0, mod_next_q};
      end else if (paddr == psdc_pkg::ADDR_MOD_STAT) begin
        prdata_d = {20'h0, mod_en_q};
      end else if (paddr == psdc_pkg::ADDR_CORE_RST) begin
        prdata_d = {29'h0, core_rst_q};
      end else if (paddr == psdc_pkg::ADDR_EMU) begin
        prdata_d = {30'h0, emu_ctl_q};
      end else begin
        prdata_d = psdc_pkg::RDATA_ZERO;
      end
    end
  end

  // Transition sequencer; one shared sequencer keeps memory-before-clock ordering simple
  always_comb begin
    state_d   = state_q;
    pd_on_d   = pd_on_q;
    mod_en_d  = mod_en_q;
    clk_on_d  = clk_on_q;
    go_pend_d = go_pend_q;
    wait_d    = wait_q;
    case (state_q)
      psdc_pkg::PSDC_IDLE: begin
        if (wr_stb && paddr == psdc_pkg::ADDR_GO && !emu_hold_all) begin
          go_pend_d = pwdata[NUM_PD-1:0] & psdc_pkg::PD_SWITCHABLE; // [RL1] [RL14]
          if ((pwdata[NUM_PD-1:0] & psdc_pkg::PD_SWITCHABLE) != '0) begin
            state_d = psdc_pkg::PSDC_WAKE_MEM;
          end
        end
      end
      psdc_pkg::PSDC_WAKE_MEM: begin
        pd_on_d = pd_on_q | (pd_next_q & go_pend_q); // [RL2] [RL8] [RL13]
        wait_d  = 2'(psdc_pkg::STEP_WAIT);
        state_d = psdc_pkg::PSDC_START_CLK;
      end
      psdc_pkg::PSDC_START_CLK: begin
        if (wait_q != 2'h0) begin
          wait_d = wait_q - 2'h1;
        end else begin
          clk_on_d = clk_on_q | mod_target; // [RL3] [RL4] [RL13]
          state_d  = psdc_pkg::PSDC_WAIT_ACK;
        end
      end
      psdc_pkg::PSDC_WAIT_ACK: begin
        if ((ack_need & ~clk_src_ack) == '0) begin // [RL3]
          state_d = psdc_pkg::PSDC_RELEASE;
        end
      end
      psdc_pkg::PSDC_RELEASE: begin
        mod_en_d  = mod_en_q | mod_target; // [RL11] [RL13]
        go_pend_d = '0; // [RL12]
        state_d   = psdc_pkg::PSDC_IDLE;
      end
      default: begin
        state_d = psdc_pkg::PSDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_on_q    <= psdc_pkg::PD_RESET; // [RL10] [RL15]
      pd_next_q  <= '0;
      mod_en_q   <= '0; // [RL15]
      mod_next_q <= '0;
      clk_on_q   <= '0;
      core_rst_q <= psdc_pkg::CORE_RST_INIT;
      go_pend_q  <= '0;
      emu_ctl_q  <= '0;
      prdata_q   <= psdc_pkg::RDATA_ZERO;
      wait_q     <= '0;
      state_q    <= psdc_pkg::PSDC_IDLE;
    end else begin
      pd_on_q    <= pd_on_d | psdc_pkg::PD_RESET; // [RL5]
      pd_next_q  <= pd_next_d;
      mod_en_q   <= mod_en_d;
      mod_next_q <= mod_next_d;
      clk_on_q   <= clk_on_d;
      core_rst_q <= core_rst_d;
      go_pend_q  <= go_pend_d;
      emu_ctl_q  <= emu_ctl_d;
      prdata_q   <= prdata_d;
      wait_q     <= wait_d;
      state_q    <= state_d;
    end
  end

  // Outputs; always-on modules never gated or reset here
  always_comb begin
    prdata             = prdata_q;
    transition_pending = |go_pend_q; // [RL12]
    mem_sleep          = ~pd_on_q; // [RL10]
    mod_out.clk_stop_req = ~(clk_on_q | psdc_pkg::MOD_ALWAYS_ON) & psdc_pkg::MOD_DEDICATED; // [RL3]
    mod_out.clk_gate_en  = (clk_on_q & ~psdc_pkg::MOD_DEDICATED) | psdc_pkg::MOD_ALWAYS_ON; // [RL4] [RL7]
    mod_out.mod_rst_n    = mod_en_q | psdc_pkg::MOD_ALWAYS_ON; // [RL11]
    mod_out.core_local_reset_n = core_rst_q; // [RL1]
  end

  a_pend_clear_state: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(transition_pending) |-> $past(state_q) == psdc_pkg::PSDC_RELEASE) // [RL12]
    else $error("pending cleared before release");
  a_perm_domain_on: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_sleep[0]) // [RL5]
    else $error("permanent domain asleep");
  a_order_mem_clk: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mod_out.mod_rst_n[6]) |-> !mem_sleep[1] && $past(mod_out.clk_gate_en[6] | ~mod_out.clk_stop_req[6])) // [RL13]
    else $error("reset released before clock or memory");
  a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !mod_en_q[0] && !mod_en_q[8] && !pd_on_q[3]) // [RL14]
    else $error("reserved index changed");
  a_always_on_mods: assert property (@(posedge pclk) disable iff (!presetn)
    mod_out.mod_rst_n[11] && mod_out.clk_gate_en[3]) // [RL7]
    else $error("always on module gated");
  a_emu_hold_go: assert property (@(posedge pclk) disable iff (!presetn)
    emu_hold_all && state_q == psdc_pkg::PSDC_IDLE |=> state_q == psdc_pkg::PSDC_IDLE) // [RL9]
    else $error("transition started under hold");
  a_wake_to_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == psdc_pkg::PSDC_WAKE_MEM |=> state_q == psdc_pkg::PSDC_START_CLK [*3]) // [RL2]
    else $error("memory wake spacing wrong");
  a_held_clk_off: assert property (@(posedge pclk) disable iff (!presetn)
    !mod_out.mod_rst_n[9] |-> !clk_on_q[9] || state_q != psdc_pkg::PSDC_IDLE) // [RL11]
    else $error("held module clock running");
endmodule

// ### bench/psdc_clkgen_model.sv
`timescale 1ns/1ps
module psdc_clkgen_model #(
  parameter int unsigned NUM_MOD = 12
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [NUM_MOD-1:0] stop_req,
  input  wire logic [3:0]         lag,
  output logic      [NUM_MOD-1:0] ack
);
  logic [3:0] cnt;
  // Source stops at once, restarts only after lag cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= '0;
      cnt <= '0;
    end else if ((~stop_req & ~ack) != '0 && cnt < lag) begin
      cnt <= cnt + 4'h1;
      ack <= ack & ~stop_req;
    end else begin
      cnt <= '0;
      ack <= ~stop_req;
    end
  end
endmodule

// ### bench/tb_power_sleep_domain_controller.sv
`timescale 1ns/1ps
module tb_power_sleep_domain_controller;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        emu_hold, emu_force_on, transition_pending, prev6;
  logic [11:0] paddr, ack;
  logic [31:0] pwdata, prdata, rnd, exp_q[$];
  logic [5:0]  mem_sleep;
  logic [3:0]  lag;
  psdc_pkg::psdc_out_s mod_out;
  int          failures, n_compared;

  psdc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_src_ack(ack), .emu_hold(emu_hold), .emu_force_on(emu_force_on),
    .mem_sleep(mem_sleep), .mod_out(mod_out), .transition_pending(transition_pending));
  psdc_clkgen_model i_gen (.pclk(pclk), .presetn(presetn), .stop_req(mod_out.clk_stop_req),
    .lag(lag), .ack(ack));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      failures++;
      tally_and_finish();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 300 && transition_pending !== 1'b0; n++) @(posedge pclk);
    if (n == 300) begin failures++; tally_and_finish(); end
  endtask

  // Read results checked at the access edge, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check(prdata, exp_q.pop_front());
    if (presetn && mod_out.mod_rst_n[6] && !prev6)
      check({mem_sleep[1], mod_out.clk_stop_req[6], ack[6]}, 32'h1);
    prev6 <= mod_out.mod_rst_n[6];
  end

  initial begin
    {psel, penable, pwrite, emu_hold, emu_force_on} = '0;
    paddr = '0; pwdata = '0; rnd = 32'h6F66; lag = 4'hF; presetn = 1'b0;
    failures = 0; n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check(mem_sleep, 6'h3E);
    check(mod_out.clk_stop_req, 12'h0C0);
    check(mod_out.clk_gate_en, 12'h838);
    check(mod_out.mod_rst_n, 12'h838);
    check(mod_out.core_local_reset_n, 3'h7);
    rd(psdc_pkg::ADDR_PEND, 32'h0000_0000);
    rd(12'h040, psdc_pkg::RDATA_ZERO);
    check(pslverr, 1'b0);
    // One domain only, slow clock source
    apb(1'b1, psdc_pkg::ADDR_PD_NEXT, 32'h0000_0002);
    apb(1'b1, psdc_pkg::ADDR_GO, 32'h0000_0036);
    // Pending shows every switchable domain of the trigger
    rd(psdc_pkg::ADDR_PEND, 32'h0000_0036);
    wait_idle();
    check(mem_sleep, 6'h3C);
    check(mod_out.mod_rst_n, 12'h838);
    rd(psdc_pkg::ADDR_PD_STAT, 32'h0000_0003);
    // Emulation hold by pin, then by register bit, refuses a trigger
    emu_hold <= 1'b1;
    apb(1'b1, psdc_pkg::ADDR_PD_NEXT, 32'h0000_003F);
    apb(1'b1, psdc_pkg::ADDR_MOD_NEXT, 32'h0000_0FFF);
    apb(1'b1, psdc_pkg::ADDR_GO, 32'h0000_003F);
    repeat (8) @(posedge pclk);
    check(transition_pending, 1'b0);
    check(mem_sleep, 6'h3C);
    rd(psdc_pkg::ADDR_PD_NEXT, 32'h0000_0036);
    rd(psdc_pkg::ADDR_MOD_NEXT, 32'h0000_06C0);
    emu_hold <= 1'b0;
    apb(1'b1, psdc_pkg::ADDR_EMU, 32'h0000_0001);
    apb(1'b1, psdc_pkg::ADDR_GO, 32'h0000_003F);
    repeat (8) @(posedge pclk);
    check(transition_pending, 1'b0);
    rd(psdc_pkg::ADDR_EMU, 32'h0000_0001);
    // Force pin alone picks the modules; random source lag
    apb(1'b1, psdc_pkg::ADDR_EMU, 32'h0000_0000);
    apb(1'b1, psdc_pkg::ADDR_MOD_NEXT, 32'h0000_0000);
    rnd = lfsr(rnd);
    lag <= rnd[3:0];
    emu_force_on <= 1'b1;
    apb(1'b1, psdc_pkg::ADDR_GO, 32'h0000_003F);
    // Pending rises only after the trigger edge has settled
    repeat (3) @(posedge pclk);
    wait_idle();
    check(mem_sleep, 6'(~psdc_pkg::PD_SWITCHABLE & ~psdc_pkg::PD_RESET));
    check(mod_out.clk_stop_req, 12'h000);
    check(mod_out.clk_gate_en, psdc_pkg::MOD_ALWAYS_ON | 12'h600);
    check(mod_out.mod_rst_n, psdc_pkg::MOD_ALWAYS_ON | psdc_pkg::MOD_SWITCHABLE);
    rd(psdc_pkg::ADDR_MOD_STAT, 32'h0000_06C0);
    rd(psdc_pkg::ADDR_PD_STAT, 32'h0000_0037);
    // Random core local reset values
    repeat (3) begin
      rnd = lfsr(rnd);
      apb(1'b1, psdc_pkg::ADDR_CORE_RST, {29'h0, rnd[2:0]});
      @(posedge pclk);
      check(mod_out.core_local_reset_n, rnd[2:0]);
      rd(psdc_pkg::ADDR_CORE_RST, {29'h0, rnd[2:0]});
    end
    check(mem_sleep[0], 1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    check(mod_out.clk_stop_req, 12'h0C0);
    check(mod_out.clk_gate_en, 12'h838);
    check(mod_out.mod_rst_n, 12'h838);
    check(mod_out.core_local_reset_n, 3'h7);
    check(mem_sleep, 6'h3E);
    presetn <= 1'b1;
    emu_force_on <= 1'b0;
    // Force by register bit after the second reset, memories woken with it
    apb(1'b1, psdc_pkg::ADDR_PD_NEXT, 32'h0000_0036);
    apb(1'b1, psdc_pkg::ADDR_EMU, 32'h0000_0002);
    apb(1'b1, psdc_pkg::ADDR_GO, 32'h0000_0036);
    repeat (3) @(posedge pclk);
    wait_idle();
    check(mod_out.mod_rst_n, psdc_pkg::MOD_ALWAYS_ON | psdc_pkg::MOD_SWITCHABLE);
    check(mem_sleep, 6'h08);
    tally_and_finish();
  end
endmodule
